/* hdl/pefm_pkg.sv */
// Package: register map, field positions and reset values for the fault monitor
package pefm_pkg;
  localparam int PEFM_AW = 6;
  localparam logic [PEFM_AW-1:0] PEFM_OFF_CTRL = 6'h00;
  localparam logic [PEFM_AW-1:0] PEFM_OFF_STATUS = 6'h04;
  localparam logic [PEFM_AW-1:0] PEFM_OFF_MASK = 6'h08;
  localparam logic [PEFM_AW-1:0] PEFM_OFF_TONER_LOW = 6'h0C;
  localparam logic [PEFM_AW-1:0] PEFM_OFF_TONER_OUT = 6'h10;
  localparam logic [PEFM_AW-1:0] PEFM_OFF_STATE = 6'h14;
  localparam logic [PEFM_AW-1:0] PEFM_OFF_ERRCODE = 6'h18;
  localparam int PEFM_NFLT = 7;
  localparam int PEFM_F_TAG = 0;
  localparam int PEFM_F_ABSENT = 1;
  localparam int PEFM_F_LOW = 2;
  localparam int PEFM_F_OUT = 3;
  localparam int PEFM_F_BEAM = 4;
  localparam int PEFM_F_START = 5;
  localparam int PEFM_F_ROT = 6;
  localparam int PEFM_C_START = 0;
  localparam int PEFM_C_PRINT = 1;
  localparam int PEFM_C_STOP = 2;
  localparam logic [1:0] PEFM_RESP_OKAY = 2'h0;
  localparam logic [1:0] PEFM_RESP_SLVERR = 2'h2;
  localparam logic [7:0] PEFM_TONER_LOW_RST = 8'h20;
  localparam logic [7:0] PEFM_TONER_OUT_RST = 8'h08;
  localparam logic [PEFM_NFLT-1:0] PEFM_MASK_RST = 7'h00;
  localparam logic [3:0] PEFM_ERR_NONE = 4'h0;
  localparam logic [3:0] PEFM_ERR_NO_BEAM = 4'h1;
  localparam logic [3:0] PEFM_ERR_BEAM_RDY = 4'h2;
  localparam logic [3:0] PEFM_ERR_MOT_START = 4'h3;
  localparam logic [3:0] PEFM_ERR_BEAM_START = 4'h4;
  localparam logic [3:0] PEFM_ERR_MOT_PRINT = 4'h5;
  localparam logic [3:0] PEFM_ERR_BEAM_PRINT = 4'h6;
  typedef enum logic [1:0] {PEFM_IDLE, PEFM_START, PEFM_READY, PEFM_PRINT} pefm_scan_e;
endpackage

/* hdl/pefm_scan_if.sv */
// Interface: scanner supervision control and fault results between top and scanner watcher
`timescale 1ns/1ps
interface pefm_scan_if;
  logic start;
  logic print;
  logic stop;
  logic beam_pulse;
  logic motor_locked;
  logic fault;
  logic [3:0] err_code;
  logic [1:0] state;
  modport top (output start, output print, output stop, output beam_pulse, output motor_locked,
    input fault, input err_code, input state);
  modport watch (input start, input print, input stop, input beam_pulse, input motor_locked,
    output fault, output err_code, output state);
endinterface

/* hdl/pefm_scan_watch.sv */
// Scanner watcher: beam sweep and motor speed supervision per phase
`timescale 1ns/1ps
module pefm_scan_watch #(
  parameter int START_TMO = 100000,
  parameter int READY_TMO = 20000,
  parameter int PRINT_TMO = 20000,
  parameter int BEAM_NOM = 1000,
  parameter int BEAM_TOL = 20
) (
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  pefm_scan_if.watch sif
);
  import pefm_pkg::*;
  pefm_scan_e state;
  logic [31:0] phase_cnt;
  logic [31:0] gap_cnt;
  logic seen_beam;
  logic good_gap;
  logic fault;
  logic [3:0] err_code;
  wire gap_ok = sif.beam_pulse && seen_beam && (gap_cnt >= 32'(BEAM_NOM - BEAM_TOL))
    && (gap_cnt <= 32'(BEAM_NOM + BEAM_TOL));
  wire start_tmo = (state == PEFM_START) && (phase_cnt >= 32'(START_TMO));
  wire ready_tmo = (state == PEFM_READY) && (phase_cnt >= 32'(READY_TMO));
  wire print_tmo = (state == PEFM_PRINT) && (phase_cnt >= 32'(PRINT_TMO));
  // Fault arbitration fixes one error code per event
  logic [3:0] next_err;
  always_comb begin
    next_err = PEFM_ERR_NONE;
    if (start_tmo && !seen_beam) begin
      next_err = PEFM_ERR_NO_BEAM;
    end else if (start_tmo && !sif.motor_locked) begin
      next_err = PEFM_ERR_MOT_START;
    end else if (start_tmo && !good_gap) begin
      next_err = PEFM_ERR_BEAM_START;
    end else if (ready_tmo) begin
      next_err = PEFM_ERR_BEAM_RDY;
    end else if (print_tmo && !sif.motor_locked) begin
      next_err = PEFM_ERR_MOT_PRINT;
    end else if (print_tmo) begin
      next_err = PEFM_ERR_BEAM_PRINT;
    end
  end
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state <= PEFM_IDLE;
      phase_cnt <= '0;
      gap_cnt <= '0;
      seen_beam <= 1'b0;
      good_gap <= 1'b0;
      fault <= 1'b0;
      err_code <= PEFM_ERR_NONE;
    end else begin
      fault <= 1'b0;
      gap_cnt <= sif.beam_pulse ? 32'h0 : gap_cnt + 32'h1;
      if (sif.beam_pulse) begin
        seen_beam <= 1'b1;
      end
      if (gap_ok) begin
        good_gap <= 1'b1;
      end
      phase_cnt <= phase_cnt + 32'h1;
      if (next_err != PEFM_ERR_NONE) begin
        fault <= 1'b1;
        err_code <= next_err;
        state <= PEFM_IDLE;
      end else if (sif.stop) begin
        state <= PEFM_IDLE;
      end else begin
        case (state)
          PEFM_IDLE: begin
            if (sif.start) begin
              state <= PEFM_START;
              phase_cnt <= '0;
              seen_beam <= 1'b0;
              good_gap <= 1'b0;
            end
          end
          PEFM_START: begin
            if (seen_beam && good_gap && sif.motor_locked) begin
              state <= PEFM_READY;
              phase_cnt <= '0;
            end
          end
          PEFM_READY, PEFM_PRINT: begin
            // Each good interval rearms the watchdog; in print it must also come with motor locked
            if (gap_ok && (state == PEFM_READY || sif.motor_locked)) begin
              phase_cnt <= '0;
            end
            if (state == PEFM_READY && sif.print) begin
              state <= PEFM_PRINT;
              phase_cnt <= '0;
            end else if (state == PEFM_PRINT && !sif.print) begin
              state <= PEFM_READY;
              phase_cnt <= '0;
            end
          end
          default: state <= PEFM_IDLE;
        endcase
      end
    end
  end
  assign sif.fault = fault;
  assign sif.err_code = err_code;
  assign sif.state = state;

  property p_start_tmo;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
      (start_tmo && !seen_beam) |=> (fault && err_code == PEFM_ERR_NO_BEAM && state == PEFM_IDLE);
  endproperty
  a_start_tmo: assert property (p_start_tmo) else $error("missing beam at start not flagged");
  property p_ready_tmo;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
      (ready_tmo && !start_tmo) |=> (fault && err_code == PEFM_ERR_BEAM_RDY);
  endproperty
  a_ready_tmo: assert property (p_ready_tmo) else $error("beam interval after ready not flagged");
  property p_motor_start;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
      (start_tmo && seen_beam && !sif.motor_locked) |=> (err_code == PEFM_ERR_MOT_START);
  endproperty
  a_motor_start: assert property (p_motor_start) else $error("motor start failure not flagged");
  property p_beam_start;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
      (start_tmo && seen_beam && sif.motor_locked && !good_gap) |=> (err_code == PEFM_ERR_BEAM_START);
  endproperty
  a_beam_start: assert property (p_beam_start) else $error("start interval failure not flagged");
  property p_motor_print;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
      (print_tmo && !sif.motor_locked) |=> (fault && err_code == PEFM_ERR_MOT_PRINT);
  endproperty
  a_motor_print: assert property (p_motor_print) else $error("print rotation failure not flagged");
  property p_beam_print;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
      (print_tmo && sif.motor_locked) |=> (fault && err_code == PEFM_ERR_BEAM_PRINT);
  endproperty
  a_beam_print: assert property (p_beam_print) else $error("print interval failure not flagged");
endmodule

/* hdl/pefm_top.sv */
// Top: print engine fault monitor with AXI4-Lite registers and interrupt
//
// Our own choices: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ps
module pefm_top #(
  parameter int START_TMO = 100000,
  parameter int READY_TMO = 20000,
  parameter int PRINT_TMO = 20000,
  parameter int BEAM_NOM = 1000,
  parameter int BEAM_TOL = 20
) (
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  input wire logic [pefm_pkg::PEFM_AW-1:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic [pefm_pkg::PEFM_AW-1:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  input wire logic cartridge_present_sensor_in,
  input wire logic door_closed_in,
  input wire logic tag_access_done_in,
  input wire logic tag_access_fail_in,
  input wire logic [7:0] toner_level_in,
  input wire logic beam_sweep_pulse_in,
  input wire logic motor_locked_in,
  output logic irq_out
);
  import pefm_pkg::*;
  pefm_scan_if sif ();

  // Pin synchronisers: stage one feeds stage two only
  logic [4:0] sync1;
  logic [4:0] sync2;
  logic [7:0] toner1;
  logic [7:0] toner2;
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sync1 <= '0;
      sync2 <= '0;
      toner1 <= '0;
      toner2 <= '0;
    end else begin
      sync1 <= {motor_locked_in, beam_sweep_pulse_in, tag_access_fail_in, tag_access_done_in,
        door_closed_in};
      sync2 <= sync1;
      toner1 <= toner_level_in;
      toner2 <= toner1;
    end
  end
  wire door_s = sync2[0];
  wire tag_done_s = sync2[1];
  wire tag_fail_s = sync2[2];
  wire beam_s = sync2[3];
  wire lock_s = sync2[4];
  logic door_d;
  logic tag_done_d;
  logic beam_d;
  logic por_done;
  wire door_rise = door_s && !door_d;
  wire beam_rise = beam_s && !beam_d;
  // Tag failure is a qualified completion edge so one failed access sets once
  wire tag_err_ev = tag_done_s && !tag_done_d && tag_fail_s;
  // Presence sampled every cycle of the power-on window or on door close
  logic pres1;
  logic pres2;
  wire pres_sample = !por_done || door_rise;
  wire absent_ev = pres_sample && !pres2;

  // Registers
  logic [2:0] ctrl_pulse;
  logic [PEFM_NFLT-1:0] status;
  logic [PEFM_NFLT-1:0] mask;
  logic [7:0] toner_low_thr;
  logic [7:0] toner_out_thr;
  logic print_en;
  wire toner_out_ev = toner2 < toner_out_thr;
  wire toner_low_ev = toner2 < toner_low_thr;
  logic [PEFM_NFLT-1:0] ev;
  always_comb begin
    ev = '0;
    ev[PEFM_F_TAG] = tag_err_ev;
    ev[PEFM_F_ABSENT] = absent_ev;
    ev[PEFM_F_LOW] = toner_low_ev;
    ev[PEFM_F_OUT] = toner_out_ev;
    ev[PEFM_F_BEAM] = sif.fault && (sif.err_code == PEFM_ERR_NO_BEAM || sif.err_code == PEFM_ERR_BEAM_RDY);
    ev[PEFM_F_START] = sif.fault && (sif.err_code == PEFM_ERR_MOT_START || sif.err_code == PEFM_ERR_BEAM_START);
    ev[PEFM_F_ROT] = sif.fault && (sif.err_code == PEFM_ERR_MOT_PRINT || sif.err_code == PEFM_ERR_BEAM_PRINT);
  end

  // AXI4-Lite write: address and data taken in either order, response after both
  logic aw_held;
  logic w_held;
  logic [PEFM_AW-1:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic bvalid;
  logic [1:0] bresp;
  assign s_axi_awready_out = !aw_held && !bvalid;
  assign s_axi_wready_out = !w_held && !bvalid;
  wire aw_fire = s_axi_awvalid_in && s_axi_awready_out;
  wire w_fire = s_axi_wvalid_in && s_axi_wready_out;
  wire [PEFM_AW-1:0] wr_addr = aw_held ? aw_addr : s_axi_awaddr_in;
  wire [31:0] wr_data = w_held ? w_data : s_axi_wdata_in;
  wire [3:0] wr_strb = w_held ? w_strb : s_axi_wstrb_in;
  wire wr_go = (aw_held || aw_fire) && (w_held || w_fire) && !bvalid;
  wire wr_lane0 = wr_go && wr_strb[0];
  wire wr_ctrl = wr_lane0 && wr_addr == PEFM_OFF_CTRL;
  wire wr_stat = wr_lane0 && wr_addr == PEFM_OFF_STATUS;
  wire wr_mask = wr_lane0 && wr_addr == PEFM_OFF_MASK;
  wire wr_low = wr_lane0 && wr_addr == PEFM_OFF_TONER_LOW;
  wire wr_out = wr_lane0 && wr_addr == PEFM_OFF_TONER_OUT;

  function automatic logic addr_known(input logic [PEFM_AW-1:0] a);
    return a == PEFM_OFF_CTRL || a == PEFM_OFF_STATUS || a == PEFM_OFF_MASK || a == PEFM_OFF_TONER_LOW
      || a == PEFM_OFF_TONER_OUT || a == PEFM_OFF_STATE || a == PEFM_OFF_ERRCODE;
  endfunction

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= '0;
      w_data <= '0;
      w_strb <= '0;
      bvalid <= 1'b0;
      bresp <= PEFM_RESP_OKAY;
    end else begin
      if (aw_fire && !wr_go) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr_in;
      end
      if (w_fire && !wr_go) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata_in;
        w_strb <= s_axi_wstrb_in;
      end
      if (wr_go) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        bvalid <= 1'b1;
        bresp <= addr_known(wr_addr) ? PEFM_RESP_OKAY : PEFM_RESP_SLVERR;
      end else if (bvalid && s_axi_bready_in) begin
        bvalid <= 1'b0;
      end
    end
  end
  assign s_axi_bvalid_out = bvalid;
  assign s_axi_bresp_out = bresp;

  // Register state; status set wins over a same-cycle write-one clear
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      status <= '0;
      mask <= PEFM_MASK_RST;
      toner_low_thr <= PEFM_TONER_LOW_RST;
      toner_out_thr <= PEFM_TONER_OUT_RST;
      ctrl_pulse <= '0;
      print_en <= 1'b0;
      door_d <= 1'b0;
      tag_done_d <= 1'b0;
      beam_d <= 1'b0;
      por_done <= 1'b0;
      pres1 <= 1'b0;
      pres2 <= 1'b0;
    end else begin
      door_d <= door_s;
      tag_done_d <= tag_done_s;
      beam_d <= beam_s;
      pres1 <= cartridge_present_sensor_in;
      pres2 <= pres1;
      // Hold the power-on sample window until the delayed door input door_d reads closed
      if (!por_done && pres_sample) begin
        por_done <= door_d;
      end
      status <= (status & ~(wr_stat ? wr_data[PEFM_NFLT-1:0] : '0)) | ev;
      if (wr_mask) begin
        mask <= wr_data[PEFM_NFLT-1:0];
      end
      if (wr_low) begin
        toner_low_thr <= wr_data[7:0];
      end
      if (wr_out) begin
        toner_out_thr <= wr_data[7:0];
      end
      ctrl_pulse <= wr_ctrl ? wr_data[2:0] : 3'h0;
      if (wr_ctrl) begin
        print_en <= wr_data[PEFM_C_PRINT];
      end
    end
  end

  // Scanner watcher
  assign sif.start = ctrl_pulse[PEFM_C_START];
  assign sif.stop = ctrl_pulse[PEFM_C_STOP];
  assign sif.print = print_en;
  assign sif.beam_pulse = beam_rise;
  assign sif.motor_locked = lock_s;
  pefm_scan_watch #(
    .START_TMO(START_TMO),
    .READY_TMO(READY_TMO),
    .PRINT_TMO(PRINT_TMO),
    .BEAM_NOM(BEAM_NOM),
    .BEAM_TOL(BEAM_TOL)
  ) u_watch (
    .ref_clk_in(ref_clk_in),
    .rst_n_in(rst_n_in),
    .sif(sif)
  );

  // AXI4-Lite read: one outstanding read, data registered
  logic rvalid;
  logic [31:0] rdata;
  logic [1:0] rresp;
  assign s_axi_arready_out = !rvalid;
  wire ar_fire = s_axi_arvalid_in && s_axi_arready_out;
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0;
    case (s_axi_araddr_in)
      PEFM_OFF_CTRL: rd_mux = {30'h0, print_en, 1'b0};
      PEFM_OFF_STATUS: rd_mux = 32'(status);
      PEFM_OFF_MASK: rd_mux = 32'(mask);
      PEFM_OFF_TONER_LOW: rd_mux = {24'h0, toner_low_thr};
      PEFM_OFF_TONER_OUT: rd_mux = {24'h0, toner_out_thr};
      PEFM_OFF_STATE: rd_mux = {22'h0, pres2, 5'h0, toner2[1:0] & 2'h0, sif.state};
      PEFM_OFF_ERRCODE: rd_mux = {28'h0, sif.err_code};
      default: rd_mux = 32'h0;
    endcase
  end
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= PEFM_RESP_OKAY;
    end else begin
      if (ar_fire) begin
        rvalid <= 1'b1;
        rdata <= rd_mux;
        rresp <= addr_known(s_axi_araddr_in) ? PEFM_RESP_OKAY : PEFM_RESP_SLVERR;
      end else if (rvalid && s_axi_rready_in) begin
        rvalid <= 1'b0;
      end
    end
  end
  assign s_axi_rvalid_out = rvalid;
  assign s_axi_rdata_out = rdata;
  assign s_axi_rresp_out = rresp;

  // Level interrupt, no registered stage so clears act at once
  assign irq_out = |(status & mask);

  property p_tag;
    @(posedge ref_clk_in) disable iff (!rst_n_in) tag_err_ev |=> status[PEFM_F_TAG];
  endproperty
  a_tag: assert property (p_tag) else $error("tag error not latched");
  property p_door;
    @(posedge ref_clk_in) disable iff (!rst_n_in) (por_done && door_rise && !pres2) |=> status[PEFM_F_ABSENT];
  endproperty
  a_door: assert property (p_door) else $error("absence on door close not latched");
  property p_absent;
    @(posedge ref_clk_in) disable iff (!rst_n_in) absent_ev |=> status[PEFM_F_ABSENT];
  endproperty
  a_absent: assert property (p_absent) else $error("absence flag lost");
  property p_toner;
    @(posedge ref_clk_in) disable iff (!rst_n_in) (toner2 < toner_out_thr) |=> status[PEFM_F_OUT];
  endproperty
  a_toner: assert property (p_toner) else $error("toner out not flagged");
  property p_scan;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
      sif.fault |=> (status[PEFM_F_BEAM] || status[PEFM_F_START] || status[PEFM_F_ROT]);
  endproperty
  a_scan: assert property (p_scan) else $error("scanner fault not reported");
  property p_sticky;
    @(posedge ref_clk_in) disable iff (!rst_n_in) (status[PEFM_F_TAG] && !wr_stat) |=> status[PEFM_F_TAG];
  endproperty
  a_sticky: assert property (p_sticky) else $error("flag dropped without clear");
  // Bus answers stand until the master takes them
  property p_bvalid_hold;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
      (bvalid && !s_axi_bready_in) |=> (bvalid && $stable(bresp));
  endproperty
  a_bvalid_hold: assert property (p_bvalid_hold) else $error("write response dropped early");
  property p_rvalid_hold;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
      (rvalid && !s_axi_rready_in) |=> (rvalid && $stable(rdata) && $stable(rresp));
  endproperty
  a_rvalid_hold: assert property (p_rvalid_hold) else $error("read data dropped early");
  property p_low;
    @(posedge ref_clk_in) disable iff (!rst_n_in) (toner2 < toner_low_thr) |=> status[PEFM_F_LOW];
  endproperty
  a_low: assert property (p_low) else $error("toner low not flagged");
  // Power-on window samples presence every cycle
  sequence s_por_absent;
    !por_done && !pres2;
  endsequence
  property p_por;
    @(posedge ref_clk_in) disable iff (!rst_n_in) s_por_absent |=> status[PEFM_F_ABSENT];
  endproperty
  a_por: assert property (p_por) else $error("absence at power-on not latched");
  // A good access must leave the tag flag clear
  sequence s_tag_ok;
    tag_done_s && !tag_done_d && !tag_fail_s && !status[PEFM_F_TAG];
  endsequence
  property p_tag_ok;
    @(posedge ref_clk_in) disable iff (!rst_n_in) s_tag_ok |=> !status[PEFM_F_TAG];
  endproperty
  a_tag_ok: assert property (p_tag_ok) else $error("tag flag set on good access");
  property p_beam_flag;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
      (sif.fault && sif.err_code == PEFM_ERR_NO_BEAM) |=> status[PEFM_F_BEAM];
  endproperty
  a_beam_flag: assert property (p_beam_flag) else $error("beam failure flag missing");
  property p_start_flag;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
      (sif.fault && sif.err_code == PEFM_ERR_MOT_START) |=> status[PEFM_F_START];
  endproperty
  a_start_flag: assert property (p_start_flag) else $error("start-up failure flag missing");
  property p_rot_flag;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
      (sif.fault && sif.err_code == PEFM_ERR_MOT_PRINT) |=> status[PEFM_F_ROT];
  endproperty
  a_rot_flag: assert property (p_rot_flag) else $error("rotation failure flag missing");
  property p_absent_sticky;
    @(posedge ref_clk_in) disable iff (!rst_n_in) (status[PEFM_F_ABSENT] && !wr_stat) |=> status[PEFM_F_ABSENT];
  endproperty
  a_absent_sticky: assert property (p_absent_sticky) else $error("absence dropped without clear");
endmodule

/* testbench/pefm_scan_model.sv */
// Model of the scanner motor and beam sweep sensor facing the monitor
`timescale 1ns/1ps
module pefm_scan_model (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [7:0] period_in,
  input wire logic beam_en_in,
  input wire logic lock_en_in,
  output logic beam_out,
  output logic locked_out
);
  logic [7:0] cnt;
  logic [3:0] lock_cnt;
  // Motor spins up for a while, so lock lags the enable
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt <= 8'h00;
      lock_cnt <= 4'h0;
      beam_out <= 1'h0;
      locked_out <= 1'h0;
    end else begin
      cnt <= (cnt + 8'h01 >= period_in) ? 8'h00 : cnt + 8'h01;
      beam_out <= beam_en_in && (cnt < 8'h02);
      lock_cnt <= !lock_en_in ? 4'h0 : (lock_cnt == 4'h8 ? lock_cnt : lock_cnt + 4'h1);
      locked_out <= lock_en_in && (lock_cnt == 4'h8);
    end
  end
endmodule

/* testbench/pefm_top_bench.sv */
// Self-checking bench for the print engine fault monitor
`timescale 1ns/1ps
module pefm_top_bench;
  import pefm_pkg::*;
  logic ref_clk = 1'h0;
  logic rst_n = 1'h0;
  logic [PEFM_AW-1:0] awaddr = '0, araddr = '0;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hF;
  logic sensor = 1'h0, door = 1'h1, tdone = 1'h0, tfail = 1'h0, ben = 1'h0, len = 1'h0;
  logic [7:0] toner = 8'hFF, per = 8'h14;
  logic awready, wready, bvalid, arready, rvalid, beam, locked, irq;
  logic [1:0] bresp, rresp, rsp;
  logic [31:0] rdata, rdat;
  logic [7:0] lo, ou, lev;
  int bad_count = 0, compares = 0, seed = 19;

  always #5 ref_clk = ~ref_clk;

  pefm_top #(.START_TMO(200), .READY_TMO(200), .PRINT_TMO(200), .BEAM_NOM(20), .BEAM_TOL(2)) u_pefm_top (
    .ref_clk_in(ref_clk), .rst_n_in(rst_n),
    .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
    .s_axi_wdata_in(wdata), .s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready),
    .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
    .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready),
    .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready),
    .cartridge_present_sensor_in(sensor), .door_closed_in(door), .tag_access_done_in(tdone),
    .tag_access_fail_in(tfail), .toner_level_in(toner), .beam_sweep_pulse_in(beam),
    .motor_locked_in(locked), .irq_out(irq));

  pefm_scan_model u_pefm_scan_model (.clk_in(ref_clk), .rst_n_in(rst_n), .period_in(per),
    .beam_en_in(ben), .lock_en_in(len), .beam_out(beam), .locked_out(locked));

  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  // Both channels offered together; each dropped at the edge it is taken
  task automatic wr(input logic [PEFM_AW-1:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge ref_clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do begin
      @(posedge ref_clk);
      n++;
      if (awvalid && awready) awvalid <= 1'h0;
      if (wvalid && wready) wvalid <= 1'h0;
    end while (!(bvalid && bready) && n < 100);
    r = bresp;
    bready <= 1'h0;
    chk("write answered", n < 100, 1);
  endtask

  task automatic rd(input logic [PEFM_AW-1:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge ref_clk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do begin
      @(posedge ref_clk);
      n++;
      if (arvalid && arready) arvalid <= 1'h0;
    end while (!(rvalid && rready) && n < 100);
    d = rdata;
    r = rresp;
    rready <= 1'h0;
    chk("read answered", n < 100, 1);
  endtask

  task automatic rchk(input string nm, input logic [PEFM_AW-1:0] a, input logic [31:0] exp,
    input logic [31:0] msk);
    rd(a, rdat, rsp);
    chk(nm, rdat & msk, exp);
  endtask

  function automatic logic [31:0] toner_exp(input logic [7:0] l, input logic [7:0] lth, input logic [7:0] oth);
    return {28'h0, l < oth, l < lth, 2'h0};
  endfunction

  function automatic logic [31:0] start_state(input logic [3:0] code);
    return (code == PEFM_ERR_NO_BEAM || code == PEFM_ERR_MOT_START || code == PEFM_ERR_BEAM_START) ? 1 : 2;
  endfunction

  task automatic tag(input logic f);
    tfail <= f;
    tdone <= 1'h1;
    cyc(3);
    tdone <= 1'h0;
    tfail <= 1'h0;
    cyc(4);
  endtask

  // Phase one set up, then the far side is changed to provoke the fault
  task automatic scan(input logic [7:0] p0, input logic b0, input logic l0, input logic pr,
    input logic [7:0] p1, input logic b1, input logic l1, input logic [3:0] code, input int fb);
    per <= p0;
    ben <= b0;
    len <= l0;
    cyc(20);
    wr(PEFM_OFF_STATUS, 32'h7F, rsp);
    wr(PEFM_OFF_CTRL, 32'h1, rsp);
    cyc(150);
    rchk("state before fault", PEFM_OFF_STATE, start_state(code), 32'h3);
    if (pr) begin
      wr(PEFM_OFF_CTRL, 32'h2, rsp);
      cyc(10);
      rchk("printing state", PEFM_OFF_STATE, 32'h3, 32'h3);
    end
    per <= p1;
    ben <= b1;
    len <= l1;
    cyc(400);
    rchk("error code", PEFM_OFF_ERRCODE, {28'h0, code}, 32'hF);
    rchk("scanner flag", PEFM_OFF_STATUS, 32'h1 << fb, 32'h70);
    rchk("idle after fault", PEFM_OFF_STATE, 32'h0, 32'h3);
    wr(PEFM_OFF_CTRL, 32'h4, rsp);
  endtask

  initial begin
    repeat (30000) @(posedge ref_clk);
    bad_count++;
    end_of_test();
  end

  initial begin
    repeat (4) @(posedge ref_clk);
    rst_n <= 1'h1;
    cyc(10);
    rchk("mask reset", PEFM_OFF_MASK, {25'h0, PEFM_MASK_RST}, 32'h7F);
    rchk("low thr reset", PEFM_OFF_TONER_LOW, {24'h0, PEFM_TONER_LOW_RST}, 32'hFF);
    rchk("out thr reset", PEFM_OFF_TONER_OUT, {24'h0, PEFM_TONER_OUT_RST}, 32'hFF);
    rd(6'h1C, rdat, rsp);
    chk("unmapped read resp", rsp, PEFM_RESP_SLVERR);
    chk("unmapped read data", rdat, 32'h0);
    wr(6'h1C, 32'hFFFF_FFFF, rsp);
    chk("unmapped write resp", rsp, PEFM_RESP_SLVERR);
    rchk("absent at power-on", PEFM_OFF_STATUS, 32'h2, 32'h2);
    sensor <= 1'h1;
    cyc(4);
    wr(PEFM_OFF_STATUS, 32'h2, rsp);
    rchk("absent cleared", PEFM_OFF_STATUS, 32'h0, 32'h2);
    rchk("presence seen", PEFM_OFF_STATE, 32'h200, 32'h200);
    sensor <= 1'h0;
    cyc(10);
    rchk("no sample without door", PEFM_OFF_STATUS, 32'h0, 32'h2);
    door <= 1'h0;
    cyc(4);
    door <= 1'h1;
    cyc(6);
    rchk("absent on door close", PEFM_OFF_STATUS, 32'h2, 32'h2);
    sensor <= 1'h1;
    cyc(4);
    wr(PEFM_OFF_STATUS, 32'h2, rsp);
    tag(1'h1);
    rchk("tag failure", PEFM_OFF_STATUS, 32'h1, 32'h1);
    cyc(20);
    rchk("tag flag sticky", PEFM_OFF_STATUS, 32'h1, 32'h1);
    wr(PEFM_OFF_STATUS, 32'h1, rsp);
    tag(1'h0);
    rchk("tag success", PEFM_OFF_STATUS, 32'h0, 32'h1);
    for (int i = 0; i < 5; i++) begin
      lo = $random(seed);
      ou = $random(seed);
      lev = (i == 1) ? lo : ((i == 2) ? ou - 8'h01 : $random(seed));
      wr(PEFM_OFF_TONER_LOW, {24'h0, lo}, rsp);
      wr(PEFM_OFF_TONER_OUT, {24'h0, ou}, rsp);
      toner <= lev;
      cyc(6);
      wr(PEFM_OFF_STATUS, 32'hC, rsp);
      cyc(4);
      rchk("toner flags", PEFM_OFF_STATUS, toner_exp(lev, lo, ou), 32'hC);
    end
    toner <= 8'hFF;
    cyc(6);
    wr(PEFM_OFF_STATUS, 32'hC, rsp);
    rchk("toner flags cleared", PEFM_OFF_STATUS, 32'h0, 32'hC);
    scan(8'h14, 1, 1, 1, 8'h14, 0, 1, PEFM_ERR_BEAM_PRINT, PEFM_F_ROT);
    scan(8'h14, 0, 1, 0, 8'h14, 0, 1, PEFM_ERR_NO_BEAM, PEFM_F_BEAM);
    wr(PEFM_OFF_MASK, 32'h1 << PEFM_F_BEAM, rsp);
    cyc(2);
    chk("irq unmasked", irq, 1'h1);
    wr(PEFM_OFF_MASK, 32'h1 << PEFM_F_ROT, rsp);
    cyc(2);
    chk("irq masked", irq, 1'h0);
    wr(PEFM_OFF_MASK, 32'h7F, rsp);
    wr(PEFM_OFF_STATUS, 32'h7F, rsp);
    cyc(2);
    chk("irq cleared", irq, 1'h0);
    wr(PEFM_OFF_MASK, 32'h0, rsp);
    scan(8'h14, 1, 0, 0, 8'h14, 1, 0, PEFM_ERR_MOT_START, PEFM_F_START);
    scan(8'h1E, 1, 1, 0, 8'h1E, 1, 1, PEFM_ERR_BEAM_START, PEFM_F_START);
    scan(8'h14, 1, 1, 0, 8'h1E, 1, 1, PEFM_ERR_BEAM_RDY, PEFM_F_BEAM);
    scan(8'h14, 1, 1, 1, 8'h14, 1, 0, PEFM_ERR_MOT_PRINT, PEFM_F_ROT);
    end_of_test();
  end
endmodule
